// ---- logic/iccs_pkg.sv ----
// Constants, field layouts and carrier types of the I/O cell control select block
package iccs_pkg;

    // ******************************************************************
    // Sizes
    // ******************************************************************
    localparam int NUM_LINES = 12;
    localparam int NUM_DED   = 6;
    localparam int NUM_DCLK  = 2;
    localparam int NUM_GLOB  = 4;
    localparam int NUM_DOE   = 8;
    localparam int NUM_TICK  = 6;
    localparam int NUM_WIPE  = 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int SRC_W     = 4;

    // ******************************************************************
    // Register offsets
    // ******************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PIN_IN    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CELL_Q    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LINE_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_CELL_BASE = 8'h80;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int CTRL_OE_OPT_BIT = 0;
    localparam int CTRL_GLOB_LSB   = 1;
    localparam int STAT_LINE_LSB   = 0;
    localparam int STAT_DED_LSB    = 12;
    localparam int STAT_RST_BIT    = 18;
    localparam int STAT_OE_BIT     = 19;

    // ******************************************************************
    // Role of each control bus line
    // ******************************************************************
    localparam int DOE_LINE    [NUM_DOE]  = '{0, 1, 2, 3, 4, 5, 7, 9};
    localparam int GLOB_LINE   [NUM_GLOB] = '{6, 7, 9, 11};
    localparam int TIMING_LINE [NUM_DCLK] = '{6, 11};
    localparam int WIPE_LINE   [NUM_WIPE] = '{8, 10};
    localparam int TICK_BASE   = 6;

    // ******************************************************************
    // Line source and cell select encodings
    // ******************************************************************
    localparam logic [SRC_W-1:0] SRC_COL      = 4'h6;
    localparam logic [SRC_W-1:0] SRC_OFF      = 4'h7;
    localparam logic [SRC_W-1:0] SRC_ROW_BASE = 4'h8;
    localparam logic [SRC_W-1:0] LINE_SRC_RST = SRC_OFF;
    localparam logic [3:0]       CE_DIRECT    = 4'h6;
    localparam logic [3:0]       CE_ALWAYS    = 4'h7;
    localparam logic [3:0]       OE_DIRECT    = 4'h8;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [1:0] {MODE_IN, MODE_OUT, MODE_BIDIR} iccs_mode_t;
    typedef enum logic [1:0] {REG_NONE, REG_IN, REG_OUT} iccs_reg_use_t;
    typedef enum logic [1:0] {CK_TIMING0, CK_TIMING1, CK_DED0, CK_DED1} iccs_clk_sel_t;
    typedef enum logic [1:0] {CLR_NONE, CLR_WIPE0, CLR_WIPE1} iccs_clr_sel_t;

    typedef struct packed {
        logic          inv_ce;
        logic          inv_oe;
        logic          inv_d;
        logic [3:0]    oe_sel;
        logic [3:0]    ce_sel;
        iccs_clr_sel_t clr_sel;
        iccs_clk_sel_t clk_sel;
        iccs_reg_use_t reg_use;
        iccs_mode_t    mode;
    } iccs_cell_cfg_t;

    localparam int             CELL_CFG_W   = $bits(iccs_cell_cfg_t);
    localparam iccs_cell_cfg_t CELL_CFG_RST = '0;

    typedef struct packed {
        logic [NUM_DCLK+NUM_DCLK-1:0] timing;
        logic [NUM_WIPE-1:0]          wipe;
        logic [NUM_TICK-1:0]          tick;
        logic [NUM_DOE-1:0]           doe;
    } iccs_ctl_t;

endpackage

// ---- logic/iccs_cell.sv ----
// One programmable I/O cell with its shared control selection
module iccs_cell (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // Chip-wide controls
    input  wire logic                     chip_rst,
    input  wire logic                     pins_off,
    // Configuration and control bus
    input  wire iccs_pkg::iccs_cell_cfg_t cfg,
    input  wire iccs_pkg::iccs_ctl_t      ctl,
    // Pin side
    input  wire logic                     pin_in,
    output logic                          pad_out,
    output logic                          pad_oe_n,
    // Routing side
    input  wire logic                     core_d,
    input  wire logic                     lc_ce,
    input  wire logic                     lc_oe,
    output logic                          core_q_in,
    output logic                          cell_q
);

    logic                    clk_sel_v;
    logic                    clk_prev_r;
    logic                    clk_edge;
    logic                    ce_v;
    logic                    oe_v;
    logic                    clr_v;
    logic                    d_v;
    logic                    drive_v;
    logic                    q_r;
    logic                    pad_out_r;
    logic                    pad_oe_n_r;
    logic                    core_q_in_r;
    iccs_pkg::iccs_reg_use_t use_v;

    // ******************************************************************
    // Control selection
    // ******************************************************************
    always_comb
    begin
        clk_sel_v = ctl.timing[cfg.clk_sel];
        clk_edge  = clk_sel_v & ~clk_prev_r;
        if (cfg.ce_sel < iccs_pkg::CE_DIRECT)
            ce_v = ctl.tick[cfg.ce_sel[2:0]];
        else if (cfg.ce_sel == iccs_pkg::CE_DIRECT)
            ce_v = lc_ce ^ cfg.inv_ce;
        else if (cfg.ce_sel == iccs_pkg::CE_ALWAYS)
            ce_v = 1'b1;
        else
            ce_v = 1'b0;
        if (cfg.oe_sel == iccs_pkg::OE_DIRECT)
            oe_v = lc_oe ^ cfg.inv_oe;
        else if (cfg.oe_sel < iccs_pkg::OE_DIRECT)
            oe_v = ctl.doe[cfg.oe_sel[2:0]] ^ cfg.inv_oe;
        else
            oe_v = 1'b0;
        case (cfg.clr_sel)
            iccs_pkg::CLR_WIPE0: clr_v = ctl.wipe[0];
            iccs_pkg::CLR_WIPE1: clr_v = ctl.wipe[1];
            default:             clr_v = 1'b0;
        endcase
        // Bidirectional pins capture input in neighbouring logic cells
        if (cfg.mode == iccs_pkg::MODE_BIDIR && cfg.reg_use == iccs_pkg::REG_IN)
            use_v = iccs_pkg::REG_NONE;
        else
            use_v = cfg.reg_use;
        d_v = (use_v == iccs_pkg::REG_IN) ? pin_in : (core_d ^ cfg.inv_d);
        case (cfg.mode)
            iccs_pkg::MODE_OUT:   drive_v = 1'b1;
            iccs_pkg::MODE_BIDIR: drive_v = oe_v;
            default:              drive_v = 1'b0;
        endcase
        if (pins_off)
            drive_v = 1'b0;
    end

    // ******************************************************************
    // Cell register
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            clk_prev_r <= 1'b0;
        else
            clk_prev_r <= clk_sel_v;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || chip_rst)
            q_r <= 1'b0;
        else if (clr_v)
            q_r <= 1'b0;
        else if (clk_edge && ce_v && use_v != iccs_pkg::REG_NONE)
            q_r <= d_v;
    end

    // ******************************************************************
    // Registered outputs
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pad_out_r   <= 1'b0;
            pad_oe_n_r  <= 1'b1;
            core_q_in_r <= 1'b0;
        end
        else
        begin
            if (use_v == iccs_pkg::REG_OUT)
                pad_out_r <= q_r & ~clr_v & ~chip_rst;
            else
                pad_out_r <= core_d ^ cfg.inv_d;
            pad_oe_n_r  <= ~drive_v;
            core_q_in_r <= (use_v == iccs_pkg::REG_IN) ? (q_r & ~clr_v & ~chip_rst) : pin_in;
        end
    end

    assign pad_out   = pad_out_r;
    assign pad_oe_n  = pad_oe_n_r;
    assign core_q_in = core_q_in_r;
    assign cell_q    = q_r;

endmodule

// ---- logic/iccs_top.sv ----
// I/O cell array with peripheral control bus, dedicated inputs and registers
//
// The implementer's own choices: the address map and the plain strobed port.
module iccs_top #(
    parameter int NUM_CELLS    = 8,
    parameter int NUM_CLUSTERS = 4
) (
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    // Register port
    input  wire logic [iccs_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [iccs_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [iccs_pkg::DATA_W-1:0]     reg_rdata,
    // Chip-wide pins
    input  wire logic                            chip_clrn,
    input  wire logic                            chip_oe,
    input  wire logic [iccs_pkg::NUM_DED-1:0]    ded_in,
    input  wire logic [iccs_pkg::NUM_DCLK-1:0]   ded_clk,
    // I/O pins
    input  wire logic [NUM_CELLS-1:0]            pad_in,
    output logic      [NUM_CELLS-1:0]            pad_out,
    output logic      [NUM_CELLS-1:0]            pad_oe_n,
    // Routing side of cells
    input  wire logic [NUM_CELLS-1:0]            core_dout,
    input  wire logic [NUM_CELLS-1:0]            lc_ce,
    input  wire logic [NUM_CELLS-1:0]            lc_oe,
    output logic      [NUM_CELLS-1:0]            core_din,
    // Bus line sources from logic
    input  wire logic [iccs_pkg::NUM_LINES-1:0]  col_route,
    input  wire logic [iccs_pkg::NUM_LINES*NUM_CLUSTERS-1:0] row_head,
    // Distribution to clusters
    output logic      [iccs_pkg::NUM_DED-1:0]    ded_ctl,
    output logic      [iccs_pkg::NUM_DED-1:0]    ded_data,
    output logic      [iccs_pkg::NUM_GLOB-1:0]   wide_fanout
);

    localparam int SYNC_W = NUM_CELLS + iccs_pkg::NUM_DED + iccs_pkg::NUM_DCLK + 2;
    // Int bounds so eight clusters cannot wrap
    localparam int ROW_LO = int'(iccs_pkg::SRC_ROW_BASE);
    localparam int ROW_HI = ROW_LO + NUM_CLUSTERS;

    logic [SYNC_W-1:0]                    sync1_r;
    logic [SYNC_W-1:0]                    sync2_r;
    logic [NUM_CELLS-1:0]                 pin_s;
    logic [iccs_pkg::NUM_DED-1:0]         ded_s;
    logic [iccs_pkg::NUM_DCLK-1:0]        dclk_s;
    logic                                 chip_rst;
    logic                                 chip_oe_s;
    logic                                 pins_off;
    logic                                 oe_opt_r;
    logic [iccs_pkg::NUM_GLOB-1:0]        glob_sel_r;
    logic [iccs_pkg::SRC_W-1:0]           line_src_r [iccs_pkg::NUM_LINES];
    logic [iccs_pkg::NUM_LINES-1:0]       line_nxt;
    logic [iccs_pkg::NUM_LINES-1:0]       line_r;
    iccs_pkg::iccs_cell_cfg_t             cell_cfg_r [NUM_CELLS];
    iccs_pkg::iccs_ctl_t                  ctl;
    logic [NUM_CELLS-1:0]                 cell_q;
    logic [iccs_pkg::NUM_GLOB-1:0]        glob_nxt;
    logic [iccs_pkg::NUM_GLOB-1:0]        glob_r;
    logic [iccs_pkg::NUM_DED-1:0]         ded_data_r;
    logic [iccs_pkg::DATA_W-1:0]          rdata_nxt;
    logic [iccs_pkg::DATA_W-1:0]          rdata_r;

    // ******************************************************************
    // Pin synchronisers
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {chip_oe, chip_clrn, ded_clk, ded_in, pad_in};
            sync2_r <= sync1_r;
        end
    end

    // Sync reset is low, so chip reset reads active at first
    assign pin_s     = sync2_r[NUM_CELLS-1:0];
    assign ded_s     = sync2_r[NUM_CELLS +: iccs_pkg::NUM_DED];
    assign dclk_s    = sync2_r[NUM_CELLS+iccs_pkg::NUM_DED +: iccs_pkg::NUM_DCLK];
    assign chip_rst  = ~sync2_r[SYNC_W-2];
    assign chip_oe_s = sync2_r[SYNC_W-1];
    assign pins_off  = oe_opt_r & ~chip_oe_s;

    // ******************************************************************
    // Control registers
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            oe_opt_r   <= 1'b0;
            glob_sel_r <= '0;
        end
        else if (reg_wr && reg_addr == iccs_pkg::OFS_CTRL)
        begin
            oe_opt_r   <= reg_wdata[iccs_pkg::CTRL_OE_OPT_BIT];
            glob_sel_r <= reg_wdata[iccs_pkg::CTRL_GLOB_LSB +: iccs_pkg::NUM_GLOB];
        end
    end

    // ******************************************************************
    // Peripheral control bus lines
    // ******************************************************************
    genvar gl;
    generate
        for (gl = 0; gl < iccs_pkg::NUM_LINES; gl++)
        begin : g_line
            localparam logic [iccs_pkg::ADDR_W-1:0] LINE_OFS =
                iccs_pkg::ADDR_W'(iccs_pkg::OFS_LINE_BASE + 4 * gl);

            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    line_src_r[gl] <= iccs_pkg::LINE_SRC_RST;
                else if (reg_wr && reg_addr == LINE_OFS)
                    line_src_r[gl] <= reg_wdata[iccs_pkg::SRC_W-1:0];
            end

            always_comb
            begin
                if (line_src_r[gl] < iccs_pkg::SRC_W'(iccs_pkg::NUM_DED))
                    line_nxt[gl] = ded_s[line_src_r[gl][2:0]];
                else if (line_src_r[gl] == iccs_pkg::SRC_COL)
                    line_nxt[gl] = col_route[gl];
                else if (int'(line_src_r[gl]) >= ROW_LO &&
                         int'(line_src_r[gl]) < ROW_HI)
                    line_nxt[gl] = row_head[gl*NUM_CLUSTERS +
                        int'(line_src_r[gl] - iccs_pkg::SRC_ROW_BASE)];
                else
                    line_nxt[gl] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            line_r <= '0;
        else
            line_r <= line_nxt;
    end

    // ******************************************************************
    // Line roles
    // ******************************************************************
    genvar gr;
    generate
        for (gr = 0; gr < iccs_pkg::NUM_DOE; gr++)
        begin : g_doe
            assign ctl.doe[gr] = line_r[iccs_pkg::DOE_LINE[gr]];
        end
        for (gr = 0; gr < iccs_pkg::NUM_TICK; gr++)
        begin : g_tick
            assign ctl.tick[gr] = line_r[iccs_pkg::TICK_BASE + gr];
        end
        for (gr = 0; gr < iccs_pkg::NUM_WIPE; gr++)
        begin : g_wipe
            assign ctl.wipe[gr] = line_r[iccs_pkg::WIPE_LINE[gr]];
        end
        for (gr = 0; gr < iccs_pkg::NUM_DCLK; gr++)
        begin : g_clk
            assign ctl.timing[gr] = line_r[iccs_pkg::TIMING_LINE[gr]];
            assign ctl.timing[iccs_pkg::NUM_DCLK + gr] = dclk_s[gr];
        end
        // Global k: bus line when selected, else dedicated input k
        for (gr = 0; gr < iccs_pkg::NUM_GLOB; gr++)
        begin : g_glob
            assign glob_nxt[gr] = glob_sel_r[gr] ? line_r[iccs_pkg::GLOB_LINE[gr]]
                                                 : ded_s[gr];
        end
    endgenerate

    // ******************************************************************
    // Dedicated input distribution
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            glob_r     <= '0;
            ded_data_r <= '0;
        end
        else
        begin
            glob_r     <= glob_nxt;
            ded_data_r <= ded_s;
        end
    end

    assign ded_ctl     = ded_s;
    assign ded_data    = ded_data_r;
    assign wide_fanout = glob_r;

    // ******************************************************************
    // I/O cells
    // ******************************************************************
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CELLS; gc++)
        begin : g_cell
            localparam logic [iccs_pkg::ADDR_W-1:0] CELL_OFS =
                iccs_pkg::ADDR_W'(iccs_pkg::OFS_CELL_BASE + 4 * gc);

            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    cell_cfg_r[gc] <= iccs_pkg::CELL_CFG_RST;
                else if (reg_wr && reg_addr == CELL_OFS)
                    cell_cfg_r[gc] <= iccs_pkg::iccs_cell_cfg_t'(
                        reg_wdata[iccs_pkg::CELL_CFG_W-1:0]);
            end

            // Each cell picks its own controls from the shared bus
            iccs_cell u_cell (
                .core_clk  (core_clk),
                .rst_n     (rst_n),
                .chip_rst  (chip_rst),
                .pins_off  (pins_off),
                .cfg       (cell_cfg_r[gc]),
                .ctl       (ctl),
                .pin_in    (pin_s[gc]),
                .pad_out   (pad_out[gc]),
                .pad_oe_n  (pad_oe_n[gc]),
                .core_d    (core_dout[gc]),
                .lc_ce     (lc_ce[gc]),
                .lc_oe     (lc_oe[gc]),
                .core_q_in (core_din[gc]),
                .cell_q    (cell_q[gc])
            );
        end
    endgenerate

    // ******************************************************************
    // Register read
    // ******************************************************************
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_addr == iccs_pkg::OFS_CTRL)
        begin
            rdata_nxt[iccs_pkg::CTRL_OE_OPT_BIT] = oe_opt_r;
            rdata_nxt[iccs_pkg::CTRL_GLOB_LSB +: iccs_pkg::NUM_GLOB] = glob_sel_r;
        end
        else if (reg_addr == iccs_pkg::OFS_STATUS)
        begin
            rdata_nxt[iccs_pkg::STAT_LINE_LSB +: iccs_pkg::NUM_LINES] = line_r;
            rdata_nxt[iccs_pkg::STAT_DED_LSB +: iccs_pkg::NUM_DED]    = ded_s;
            rdata_nxt[iccs_pkg::STAT_RST_BIT] = chip_rst;
            rdata_nxt[iccs_pkg::STAT_OE_BIT]  = chip_oe_s;
        end
        else if (reg_addr == iccs_pkg::OFS_PIN_IN)
            rdata_nxt[NUM_CELLS-1:0] = pin_s;
        else if (reg_addr == iccs_pkg::OFS_CELL_Q)
            rdata_nxt[NUM_CELLS-1:0] = cell_q;
        else
        begin
            for (int i = 0; i < iccs_pkg::NUM_LINES; i++)
                if (reg_addr == iccs_pkg::ADDR_W'(iccs_pkg::OFS_LINE_BASE + 4 * i))
                    rdata_nxt[iccs_pkg::SRC_W-1:0] = line_src_r[i];
            for (int j = 0; j < NUM_CELLS; j++)
                if (reg_addr == iccs_pkg::ADDR_W'(iccs_pkg::OFS_CELL_BASE + 4 * j))
                    rdata_nxt[iccs_pkg::CELL_CFG_W-1:0] = cell_cfg_r[j];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_r <= '0;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= '0;
    end

    // Read data stands one cycle, then zero
    assign reg_rdata = rdata_r;

endmodule

// ---- test/iccs_top_properties.sv ----
// Port-level assertions for the I/O cell control select block
module iccs_top_properties #(
    parameter int NUM_CELLS    = 8,
    parameter int NUM_CLUSTERS = 4
) (
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          rst_n,
    // Register port
    input wire logic [iccs_pkg::ADDR_W-1:0]   reg_addr,
    input wire logic [iccs_pkg::DATA_W-1:0]   reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [iccs_pkg::DATA_W-1:0]   reg_rdata,
    // Chip-wide pins and outputs
    input wire logic                          chip_clrn,
    input wire logic                          chip_oe,
    input wire logic [iccs_pkg::NUM_DED-1:0]  ded_in,
    input wire logic [NUM_CELLS-1:0]          pad_oe_n,
    input wire logic [iccs_pkg::NUM_DED-1:0]  ded_ctl,
    input wire logic [iccs_pkg::NUM_DED-1:0]  ded_data,
    input wire logic [iccs_pkg::NUM_GLOB-1:0] wide_fanout
);
    timeunit 1ns;
    timeprecision 100ps;
    logic oe_opt_r;
    logic glob_z_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the chip-oe option and global source bits
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            oe_opt_r <= 1'b0;
            glob_z_r <= 1'b1;
        end
        else if (reg_wr && reg_addr == iccs_pkg::OFS_CTRL)
        begin
            oe_opt_r <= reg_wdata[iccs_pkg::CTRL_OE_OPT_BIT];
            glob_z_r <= (reg_wdata[4:1] == 4'h0);
        end
    end
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hF0 |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_status_upper: assert property (reg_rd && reg_addr == iccs_pkg::OFS_STATUS |=> reg_rdata[31:20] == '0)
        else $error("status upper bits not zero");
    a_chip_oe_float: assert property ((oe_opt_r && !chip_oe)[*4] |-> &pad_oe_n)
        else $error("pins driven while chip output enable low");
    a_cell_q_cleared: assert property ((!chip_clrn)[*5] ##0 (reg_rd && reg_addr == iccs_pkg::OFS_CELL_Q) |=> reg_rdata == '0)
        else $error("cell register not cleared by chip reset");
    a_status_chip_rst: assert property ((!chip_clrn)[*5] ##0 (reg_rd && reg_addr == iccs_pkg::OFS_STATUS) |=> reg_rdata[18])
        else $error("chip reset not reported");
    a_ded_sync_two: assert property ($past(rst_n) && $past(rst_n, 2) |-> ded_ctl == $past(ded_in, 2))
        else $error("dedicated control path not two stages");
    a_ded_data_stage: assert property ($past(rst_n) |-> ded_data == $past(ded_ctl))
        else $error("dedicated data path not one stage behind");
    a_glob_from_ded: assert property (glob_z_r && $past(glob_z_r) && $past(rst_n) |-> {2'b00, wide_fanout} == ($past(ded_ctl) & 6'h0F))
        else $error("global line not following dedicated input");
endmodule

bind iccs_top iccs_top_properties #(.NUM_CELLS(NUM_CELLS), .NUM_CLUSTERS(NUM_CLUSTERS)) i_iccs_top_properties (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_clrn, .chip_oe,
    .ded_in, .pad_oe_n, .ded_ctl, .ded_data, .wide_fanout
);

// ---- test/iccs_board_model.sv ----
// Board-side model of the pads: resolves each two-way pin
module iccs_board_model (
    // Clock
    input  wire logic       core_clk,
    // Pad side of the block
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe_n,
    output logic      [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] last_r = 8'h00;
    always @(posedge core_clk)
        last_r <= (pad_out & ~pad_oe_n) | (last_r & pad_oe_n);
    // Released pin shows the inverse of its last driven level
    assign pad_in = (pad_out & ~pad_oe_n) | (~last_r & pad_oe_n);
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the I/O cell control select block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, rst_n, reg_wr, reg_rd, chip_clrn, chip_oe, rd_d, q_v;
    logic [7:0]  reg_addr, pad_in, pad_out, pad_oe_n, core_dout, lc_ce, lc_oe;
    logic [31:0] reg_wdata, reg_rdata, seed, exp_v, e_v, m_v;
    logic [31:0] exp_q[$], msk_q[$];
    logic [11:0] col_route, lines_v;
    logic [47:0] row_head;
    logic [5:0]  ded_in;
    logic [1:0]  ded_clk;
    int          error_cnt, samples_checked;
    iccs_top i_iccs_top (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .chip_clrn, .chip_oe, .ded_in, .ded_clk, .pad_in, .pad_out, .pad_oe_n, .core_dout, .lc_ce,
        .lc_oe, .core_din(), .col_route, .row_head, .ded_ctl(), .ded_data(), .wide_fanout());
    iccs_board_model i_iccs_board_model (.core_clk, .pad_out, .pad_oe_n, .pad_in);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w)
        begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic pulse(input int n);
        ded_clk[n] <= 1'b1;
        repeat (4) @(posedge core_clk);
        ded_clk[n] <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Read answer scoreboard
    always @(posedge core_clk)
    begin
        if (rd_d)
        begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            samples_checked++;
            if ((reg_rdata & m_v) !== e_v)
            begin
                error_cnt++;
                $display("ERROR reg_rdata expected %h seen %h", e_v, reg_rdata & m_v);
            end
        end
        rd_d <= reg_rd;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ded_in, ded_clk} = '0;
        {core_dout, lc_ce, lc_oe, col_route, row_head} = '0;
        {chip_clrn, chip_oe} = 2'b11;
        seed = 32'h025E;
        error_cnt = 0;
        samples_checked = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        acc(0, 8'h80, 32'h0, '1);
        acc(0, 8'h40, 32'h7, '1);
        acc(0, 8'hF0, 32'h0, '1);
        $display("test reset_values done");
        for (int i = 0; i < 12; i++)
            acc(1, 8'h40 + 8'(4 * i), (i % 3 == 0) ? 32'(i % 6) : (i % 3 == 1) ? 32'h6 : 32'(8 + i % 4), '0);
        repeat (3)
        begin
            ded_in <= 6'(rnd());
            col_route <= 12'(rnd());
            row_head <= 48'({rnd(), rnd()});
            repeat (6) @(posedge core_clk);
            for (int i = 0; i < 12; i++)
                lines_v[i] = (i % 3 == 0) ? ded_in[i % 6] : (i % 3 == 1) ? col_route[i] : row_head[i * 4 + i % 4];
            exp_v = {12'h0, 2'b10, ded_in, lines_v};
            acc(0, 8'h04, exp_v, '1);
        end
        $display("test line_routing done");
        for (int n = 0; n < 2; n++)
        begin
            acc(1, 8'h80, 32'h0001_0709 | (32'(n + 2) << 4), '0);
            core_dout <= 8'(rnd());
            pulse(n);
            acc(0, 8'h0C, {31'h0, ~core_dout[0]}, 32'h1);
        end
        acc(1, 8'h58, 32'h7, '0);
        acc(1, 8'h80, 32'h0001_0029, '0);
        q_v = ~core_dout[0];
        core_dout <= ~core_dout;
        pulse(0);
        acc(0, 8'h0C, {31'h0, q_v}, 32'h1);
        col_route[6] <= 1'b1;
        acc(1, 8'h58, 32'h6, '0);
        pulse(0);
        acc(0, 8'h0C, {31'h0, ~core_dout[0]}, 32'h1);
        $display("test cell_clocking done");
        chip_clrn <= 1'b0;
        core_dout <= ~core_dout;
        pulse(0);
        acc(0, 8'h0C, 32'h0, 32'hFF);
        acc(0, 8'h04, 32'h0004_0000, 32'h0004_0000);
        chip_clrn <= 1'b1;
        $display("test chip_reset done");
        acc(1, 8'h60, 32'h7, '0);
        acc(1, 8'h88, 32'h0764, '0);
        pulse(0);
        acc(0, 8'h0C, 32'h4, 32'h4);
        col_route[8] <= 1'b1;
        acc(1, 8'h60, 32'h6, '0);
        pulse(0);
        acc(0, 8'h0C, 32'h0, 32'h4);
        $display("test input_clear done");
        acc(1, 8'h84, 32'h0002_8002, '0);
        lc_oe <= 8'hFD;
        core_dout <= 8'(rnd());
        repeat (6) @(posedge core_clk);
        acc(0, 8'h08, {30'h0, core_dout[1], 1'b0}, 32'h2);
        acc(1, 8'h00, 32'h1, '0);
        chip_oe <= 1'b0;
        repeat (6) @(posedge core_clk);
        acc(0, 8'h08, {30'h0, ~core_dout[1], 1'b0}, 32'h2);
        chip_oe <= 1'b1;
        $display("test pin_drive done");
        repeat (3) @(posedge core_clk);
        wrap_up();
    end
endmodule
